// ===== src/dws_sequencer.sv
// two-channel converter waveform sequencer with apb registers
`timescale 1ns/100ps

// Functional notes
// - each channel picks software update or timed waveform mode independently
// - per channel polarity and internal or external reference selection
// - software data write updates converter directly in software mode
// - five counters: interval, updates, iterations 24-bit; two delays 16-bit
// - update period equals interval count; software programs at least 40
// - one converter strobe per update period
// - fifo loaded before start; output waits for trigger
// - trigger source is software, analog or digital
// - post-trigger mode starts at once, trigger delay ignored
// - delay mode counts trigger delay down to zero, then starts
// - trigger delay clocked by timebase or update period
// - re-trigger enable; accepts retrigger_limit more triggers
// - each trigger gives iterations waveforms; triggers while busy ignored
// - finite or infinite iteration; infinite runs until software stop
// - fitting waveform replays fifo without further host transfer
// - larger waveform refills fifo from host by dma
// - fifo holds 1024 words one channel, 512 with both
// - interwave delay counts down after each waveform, then next starts
// - interwave delay clocked by timebase or update period
// - stop mode one ends output immediately
// - stop mode two finishes current waveform
// - stop mode three finishes to a multiple of iterations
module dws_sequencer
  import dws_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timebase tick and external triggers
  input  wire logic        timebase_tick,
  input  wire logic        analog_trig,
  input  wire logic        digital_trig,
  // dma request for fifo refill
  output logic             dma_req,
  // converters
  output dws_dac_s         dac
);

  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [15:0]        ctrl0;
    logic [3:0]         ctrl1;
    logic [DAC_W-1:0]   data0;
    logic [DAC_W-1:0]   data1;
    logic [23:0]        interval;
    logic [23:0]        updates;
    logic [23:0]        iters;
    logic [15:0]        tdly;
    logic [15:0]        wdly;
    logic [15:0]        retrig;
    logic [23:0]        ui_cnt;
    logic [23:0]        uc_cnt;
    logic [23:0]        ic_cnt;
    logic [15:0]        dly_cnt;
    logic [15:0]        rt_cnt;
    logic [FIFO_AW:0]   wr_ptr;
    logic [FIFO_AW:0]   rd_ptr;
    logic [FIFO_AW:0]   wave_base;
    logic               stop_req;
    logic [1:0]         stop_mode;
    dws_state_e         st;
    logic [31:0]        rdata;
    dws_dac_s           dac;
  } dws_state_s;

  dws_state_s        s_q, s_d;
  logic [DAC_W-1:0]  mem_q [0:(1<<FIFO_AW)-1];
  logic [DAC_W-1:0]  mem_rd;

  // ***********************
  // decode
  // ***********************
  logic            wr_en, rd_en, mapped, fifo_wr;
  logic            trig, upd_tick, dly_tick, two_ch, fits, fifo_full;
  logic [FIFO_AW:0] depth, fill;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign mapped  = (paddr <= ADDR_FIFO) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;           // zero wait states, every access
  assign pslverr = psel && penable && !mapped;
  assign prdata  = s_q.rdata;
  assign dac     = s_q.dac;

  assign two_ch    = s_q.ctrl0[F_ENABLE] && s_q.ctrl1[F_ENABLE];
  assign depth     = two_ch ? FIFO_TWO_CH : FIFO_ONE_CH;
  assign fill      = s_q.wr_ptr - s_q.rd_ptr;
  assign fifo_full = (fill >= depth);
  assign fifo_wr   = wr_en && (paddr == ADDR_FIFO) && !fifo_full;
  // replay when the whole waveform fits
  assign fits      = (s_q.updates <= {13'h0000, depth});
  // ask host for more words while not fitting and space remains
  assign dma_req   = (s_q.st != S_IDLE) && !fits && !fifo_full;

  always_comb begin
    case (dws_trg_e'(s_q.ctrl0[F_TRGSRC +: 2]))
      TRG_SOFT:    trig = wr_en && (paddr == ADDR_CMD) && pwdata[C_SWTRIG];
      TRG_ANALOG:  trig = analog_trig;
      TRG_DIGITAL: trig = digital_trig;
      default:     trig = 1'b0;
    endcase
  end

  // update tick when interval count expires
  assign upd_tick = timebase_tick && (s_q.ui_cnt == ONE_24);

  always_comb begin
    if (s_q.st == S_TDELAY) begin
      dly_tick = s_q.ctrl0[F_DLY1UPD] ? upd_tick : timebase_tick;
    end else begin
      dly_tick = s_q.ctrl0[F_DLY2UPD] ? upd_tick : timebase_tick;
    end
  end

  // fifo storage, written from host data port
  always_ff @(posedge pclk) begin
    if (fifo_wr) begin
      mem_q[s_q.wr_ptr[FIFO_AW-1:0]] <= pwdata[DAC_W-1:0];
    end
  end
  assign mem_rd = mem_q[s_q.rd_ptr[FIFO_AW-1:0]];

  // ***********************
  // next state
  // ***********************
  always_comb begin
    s_d = s_q;
    s_d.dac.strobe = 2'b00;
    s_d.dac.bipolar = {s_q.ctrl1[F_BIPOLAR], s_q.ctrl0[F_BIPOLAR]};
    s_d.dac.extref  = {s_q.ctrl1[F_EXTREF], s_q.ctrl0[F_EXTREF]};

    // register writes
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL0:    s_d.ctrl0    = pwdata[15:0];
        ADDR_CTRL1:    s_d.ctrl1    = pwdata[3:0];
        ADDR_INTERVAL: s_d.interval = pwdata[CNT24_W-1:0];
        ADDR_UPDATES:  s_d.updates  = pwdata[CNT24_W-1:0];
        ADDR_ITERS:    s_d.iters    = pwdata[CNT24_W-1:0];
        ADDR_TRIGDLY:  s_d.tdly     = pwdata[CNT16_W-1:0];
        ADDR_WAVEDLY:  s_d.wdly     = pwdata[CNT16_W-1:0];
        ADDR_RETRIG:   s_d.retrig   = pwdata[CNT16_W-1:0];
        // software mode writes reach the converter at once
        ADDR_DATA0: begin
          s_d.data0 = pwdata[DAC_W-1:0];
          if (!s_q.ctrl0[F_TIMED]) begin
            s_d.dac.code0     = pwdata[DAC_W-1:0];
            s_d.dac.strobe[0] = 1'b1;
          end
        end
        ADDR_DATA1: begin
          s_d.data1 = pwdata[DAC_W-1:0];
          if (!s_q.ctrl1[F_TIMED]) begin
            s_d.dac.code1     = pwdata[DAC_W-1:0];
            s_d.dac.strobe[1] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (fifo_wr) begin
      s_d.wr_ptr = s_q.wr_ptr + ONE_PTR;
    end

    // register reads, registered into the access phase data
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL0:    s_d.rdata = {16'h0000, s_q.ctrl0};
        ADDR_CTRL1:    s_d.rdata = {28'h0000000, s_q.ctrl1};
        ADDR_STATUS:   s_d.rdata = {18'h00000, fill, 1'b0,
                                    s_q.stop_req, s_q.st != S_IDLE};
        ADDR_DATA0:    s_d.rdata = {20'h00000, s_q.data0};
        ADDR_DATA1:    s_d.rdata = {20'h00000, s_q.data1};
        ADDR_INTERVAL: s_d.rdata = {8'h00, s_q.interval};
        ADDR_UPDATES:  s_d.rdata = {8'h00, s_q.updates};
        ADDR_ITERS:    s_d.rdata = {8'h00, s_q.iters};
        ADDR_TRIGDLY:  s_d.rdata = {16'h0000, s_q.tdly};
        ADDR_WAVEDLY:  s_d.rdata = {16'h0000, s_q.wdly};
        ADDR_RETRIG:   s_d.rdata = {16'h0000, s_q.retrig};
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end

    // interval counter runs on every timebase tick, in every state
    if (timebase_tick) begin
      s_d.ui_cnt = (s_q.ui_cnt <= ONE_24) ? s_q.interval : s_q.ui_cnt - ONE_24;
    end

    // stop command latches the selected mode
    if (wr_en && paddr == ADDR_CMD && pwdata[C_STOP] && s_q.st != S_IDLE) begin
      s_d.stop_req  = 1'b1;
      s_d.stop_mode = s_q.ctrl0[F_STOPM +: 2];
    end

    case (s_q.st)
      S_IDLE: begin
        if (wr_en && paddr == ADDR_CMD && pwdata[C_ARM]) begin
          s_d.st       = S_ARMED;
          s_d.rt_cnt   = s_q.retrig;
          s_d.stop_req = 1'b0;
          s_d.rd_ptr   = s_q.wr_ptr - fill;
          s_d.wave_base = s_q.rd_ptr;
        end
      end
      S_ARMED, S_WAIT: begin
        if (trig) begin
          s_d.ic_cnt = s_q.iters;
          s_d.uc_cnt = s_q.updates;
          s_d.ui_cnt = s_q.interval;
          s_d.wave_base = s_q.rd_ptr;
          if (s_q.st == S_WAIT) begin
            s_d.rt_cnt = s_q.rt_cnt - ONE_16;
          end
          if (s_q.ctrl0[F_DLYTRIG] && s_q.tdly != 16'h0000) begin
            s_d.dly_cnt = s_q.tdly;
            s_d.st      = S_TDELAY;
          end else begin
            s_d.st = S_RUN;
          end
        end
      end
      S_TDELAY: begin
        if (dly_tick) begin
          s_d.dly_cnt = s_q.dly_cnt - ONE_16;
          if (s_q.dly_cnt == ONE_16) begin
            s_d.st     = S_RUN;
            s_d.ui_cnt = s_q.interval;
          end
        end
      end
      S_RUN: begin
        // one strobe per update period, from fifo data
        if (upd_tick && fill != {(FIFO_AW+1){1'b0}}) begin
          // per channel timed select, keeps a software strobe
          s_d.dac.strobe = s_d.dac.strobe | {s_q.ctrl1[F_TIMED], s_q.ctrl0[F_TIMED]};
          if (s_q.ctrl0[F_TIMED]) s_d.dac.code0 = mem_rd;
          if (s_q.ctrl1[F_TIMED]) s_d.dac.code1 = mem_rd;
          s_d.rd_ptr = s_q.rd_ptr + ONE_PTR;
          s_d.uc_cnt = s_q.uc_cnt - ONE_24;
          if (s_q.uc_cnt == ONE_24) begin
            if (fits) begin
              s_d.rd_ptr = s_q.wave_base;
            end
            s_d.uc_cnt = s_q.updates;
            s_d.ic_cnt = s_q.ic_cnt - ONE_24;
            if (s_q.stop_req && (s_q.stop_mode == STOP_WAVE ||
                (s_q.stop_mode == STOP_ITER && s_q.ic_cnt == ONE_24))) begin
              s_d.st = S_IDLE;
            // finite sets end the trigger's burst
            end else if (s_q.ic_cnt == ONE_24 && !s_q.ctrl0[F_INFIN]) begin
              // further triggers only with retrigger enabled
              s_d.st = (s_q.ctrl0[F_RETRIG] && s_q.rt_cnt != 16'h0000) ? S_WAIT : S_IDLE;
            end else begin
              if (s_q.ic_cnt == ONE_24) s_d.ic_cnt = s_q.iters;
              s_d.dly_cnt = s_q.wdly;
              s_d.st      = (s_q.wdly == 16'h0000) ? S_RUN : S_GAP;
            end
          end
        end
      end
      S_GAP: begin
        if (dly_tick) begin
          s_d.dly_cnt = s_q.dly_cnt - ONE_16;
          if (s_q.dly_cnt == ONE_16) begin
            s_d.st     = S_RUN;
            s_d.ui_cnt = s_q.interval;
          end
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    if (wr_en && paddr == ADDR_CMD && pwdata[C_STOP] &&
        s_q.ctrl0[F_STOPM +: 2] == STOP_NOW) begin
      s_d.st       = S_IDLE;
      s_d.stop_req = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ***********************
  // assertions
  // ***********************
  a_strobe_only_run:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.dac.strobe != 2'b00) |-> ($past(s_q.st) == S_RUN || $past(wr_en)))
    else $error("strobe outside run or software write");
  a_post_no_delay:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_ARMED && trig && !s_q.ctrl0[F_DLYTRIG]) |=> s_q.st == S_RUN)
    else $error("post trigger did not start at once");
  a_busy_ignore:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_RUN && trig && !upd_tick) |=> $stable(s_q.ic_cnt))
    else $error("trigger disturbed running waveform");
  a_stop_now:
    assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_CMD && pwdata[C_STOP] &&
       s_q.ctrl0[F_STOPM +: 2] == STOP_NOW) |=> s_q.st == S_IDLE)
    else $error("immediate stop ignored");
  a_sw_update:
    assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_DATA0 && !s_q.ctrl0[F_TIMED])
      |=> s_q.dac.strobe[0] && s_q.dac.code0 == $past(pwdata[DAC_W-1:0]))
    else $error("software update not applied");
  // software channel keeps its strobe during a timed update
  a_dual_strobe:
    assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_DATA1 && !s_q.ctrl1[F_TIMED]) |=> s_q.dac.strobe[1])
    else $error("software strobe lost during timed update");
  // last trigger delay count hands over to output
  a_delay_start:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_TDELAY && dly_tick && s_q.dly_cnt == ONE_16 && !wr_en) |=> s_q.st == S_RUN)
    else $error("trigger delay end did not start output");
  // last gap count starts the next waveform
  a_gap_start:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_GAP && dly_tick && s_q.dly_cnt == ONE_16 && !wr_en) |=> s_q.st == S_RUN)
    else $error("gap end did not start next waveform");
  // fitting waveform rewinds to its first word
  a_replay_rewind:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_RUN && upd_tick && fill != {(FIFO_AW+1){1'b0}} &&
       s_q.uc_cnt == ONE_24 && fits) |=> s_q.rd_ptr == $past(s_q.wave_base))
    else $error("fifo replay did not rewind");
  // iteration stop ends on the last waveform of a set
  a_iter_finish:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.st == S_RUN && upd_tick && fill != {(FIFO_AW+1){1'b0}} && s_q.uc_cnt == ONE_24 &&
       s_q.stop_req && s_q.stop_mode == STOP_ITER && s_q.ic_cnt == ONE_24) |=> s_q.st == S_IDLE)
    else $error("iteration stop did not end the set");

endmodule

// ===== src/dws_pkg.sv
// package for the two-channel converter waveform sequencer
package dws_pkg;

  // ***********************
  // register map (byte addresses)
  // ***********************
  localparam logic [7:0] ADDR_CTRL0     = 8'h00;
  localparam logic [7:0] ADDR_CTRL1     = 8'h04;
  localparam logic [7:0] ADDR_CMD       = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_DATA0     = 8'h10;
  localparam logic [7:0] ADDR_DATA1     = 8'h14;
  localparam logic [7:0] ADDR_INTERVAL  = 8'h18;
  localparam logic [7:0] ADDR_UPDATES   = 8'h1C;
  localparam logic [7:0] ADDR_ITERS     = 8'h20;
  localparam logic [7:0] ADDR_TRIGDLY   = 8'h24;
  localparam logic [7:0] ADDR_WAVEDLY   = 8'h28;
  localparam logic [7:0] ADDR_RETRIG    = 8'h2C;
  localparam logic [7:0] ADDR_FIFO      = 8'h30;

  // ***********************
  // widths and sizes
  // ***********************
  localparam int CNT24_W    = 24;
  localparam int CNT16_W    = 16;
  localparam int DAC_W      = 12;
  localparam int FIFO_AW    = 10;
  localparam logic [10:0] FIFO_ONE_CH  = 11'h400;
  localparam logic [10:0] FIFO_TWO_CH  = 11'h200;
  localparam logic [23:0] MIN_INTERVAL = 24'h000028;
  localparam logic [23:0] ONE_24       = 24'h000001;
  localparam logic [15:0] ONE_16       = 16'h0001;
  localparam logic [FIFO_AW:0] ONE_PTR = 11'h001;

  // ctrl field positions (per channel register)
  localparam int F_TIMED   = 0;
  localparam int F_BIPOLAR = 1;
  localparam int F_EXTREF  = 2;
  localparam int F_ENABLE  = 3;
  // ctrl0 only: sequencer fields
  localparam int F_TRGSRC  = 4;   // 2 bits
  localparam int F_DLYTRIG = 6;
  localparam int F_DLY1UPD = 7;
  localparam int F_DLY2UPD = 8;
  localparam int F_RETRIG  = 9;
  localparam int F_INFIN   = 10;
  localparam int F_STOPM   = 11;  // 2 bits
  // cmd bits
  localparam int C_SWTRIG  = 0;
  localparam int C_STOP    = 1;
  localparam int C_ARM     = 2;

  typedef enum logic [1:0] {TRG_SOFT, TRG_ANALOG, TRG_DIGITAL} dws_trg_e;
  typedef enum logic [1:0] {STOP_NOW, STOP_WAVE, STOP_ITER} dws_stop_e;
  typedef enum {S_IDLE, S_ARMED, S_TDELAY, S_RUN, S_GAP, S_WAIT} dws_state_e;

  // converter side bundle
  typedef struct packed {
    logic [1:0]       strobe;
    logic [1:0]       bipolar;
    logic [1:0]       extref;
    logic [DAC_W-1:0] code0;
    logic [DAC_W-1:0] code1;
  } dws_dac_s;

endpackage

// ===== bench/dws_dac_model.sv
// converter pair model: latches codes on strobe edges and counts channel 0 updates
`timescale 1ns/100ps
module dws_dac_model
  import dws_pkg::*;
(
  // clock and converter bus
  input  wire logic        pclk,
  input  wire dws_dac_s    dac,
  // observations for the bench
  output int               cnt0,
  output int               gap0,
  output logic [DAC_W-1:0] last0,
  output logic [DAC_W-1:0] last1
);
  int cyc = 0;
  int t0  = 0;

  // free cycle count, used to time the spacing of updates
  always @(posedge pclk) cyc <= cyc + 1;

  // channel 0 output changes on strobe edge
  always @(posedge dac.strobe[0]) begin
    last0 <= dac.code0;
    cnt0  <= cnt0 + 1;
    gap0  <= cyc - t0;
    t0    <= cyc;
  end

  always @(posedge dac.strobe[1]) last1 <= dac.code1;
endmodule

// ===== bench/dws_sequencer_test.sv
// self-checking bench for the converter waveform sequencer
`timescale 1ns/100ps
module dws_sequencer_test
  import dws_pkg::*;
;
  logic             pclk, presetn, psel, penable, pwrite, rerr;
  logic             pready, pslverr, dma_req, analog_trig, digital_trig;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic             timebase_tick = 1'b1;  // one timebase cycle per clock
  logic             dma_seen      = 1'b0;
  logic [DAC_W-1:0] last0, last1;
  dws_dac_s         dac;
  int               cnt0, gap0, base, lat, l0;
  int               cyc         = 0;
  int               err_count   = 0;
  int               checks_done = 0;
  int               lo[3]       = '{6, 8, 12};
  int               ge[3]       = '{0, 200, 80};
  logic [31:0]      gc[3]       = '{32'h9, 32'h9, 32'h109};
  logic [31:0]      gd[3]       = '{32'h0, 32'hC8, 32'h2};

  dws_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_tick(timebase_tick), .analog_trig(analog_trig),
    .digital_trig(digital_trig), .dma_req(dma_req), .dac(dac));
  dws_dac_model conv (.pclk(pclk), .dac(dac), .cnt0(cnt0), .gap0(gap0), .last0(last0),
    .last1(last1));

  // clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // hang guard and refill request watch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (dma_req === 1'b1) dma_seen <= 1'b1;
    if (cyc == 60000) begin
      err_count++;
      wrap_up();
    end
  end

  // *****
  // tasks
  // *****
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen, then a idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // program a four-update waveform, arm, preload words 1..4
  task automatic cfg(input logic [31:0] c, it, td, gp);
    wr(ADDR_INTERVAL, 32'h28);
    wr(ADDR_UPDATES, 32'h4);
    wr(ADDR_ITERS, it);
    wr(ADDR_TRIGDLY, td);
    wr(ADDR_WAVEDLY, gp);
    wr(ADDR_CTRL0, c);
    wr(ADDR_CMD, 32'h4);
    for (int i = 1; i <= 4; i++) wr(ADDR_FIFO, i);
    base = cnt0;
  endtask

  // trigger by source and time the first update
  task automatic fire(input int s);
    int c;
    c = cnt0;
    lat = 0;
    if (s == 0) wr(ADDR_CMD, 32'h1);
    else begin
      analog_trig  <= (s == 1);
      digital_trig <= (s == 2);
      @(posedge pclk);
      analog_trig  <= 1'b0;
      digital_trig <= 1'b0;
    end
    while (cnt0 == c && lat < 2000) begin
      lat++;
      @(posedge pclk);
    end
  endtask

  task automatic wait_cnt(input int n);
    int k;
    k = 0;
    while (cnt0 - base < n && k < 3000) begin
      k++;
      @(posedge pclk);
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    rdat = 32'h1;
    while (rdat[0] !== 1'b0 && n < 400) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    chk(rdat[0], 32'h0);
  endtask

  // *****
  // tests
  // *****
  initial begin
    {psel, penable, pwrite, analog_trig, digital_trig, presetn} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(ADDR_CTRL1, 32'hE);
    wr(ADDR_DATA1, 32'h5A5);
    wr(ADDR_DATA0, 32'h3C3);
    repeat (3) @(posedge pclk);
    chk(last1, 32'h5A5);
    chk(last0, 32'h3C3);
    chk({dac.extref[1], dac.bipolar[1]}, 32'h3);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 32'h1);
    for (int s = 0; s < 3; s++) begin
      cfg(32'h9 | (s << 4), 32'h1, 32'h0, 32'h0);
      fire(s);
      wait_idle();
      chk(cnt0 - base, 32'h4);
      chk(gap0, 32'h28);
    end
    cfg(32'h9, 32'h2, 32'h0, 32'h0);
    fire(0);
    repeat (60) @(posedge pclk);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_DATA1, 32'h2B4);
    wait_idle();
    chk(cnt0 - base, 32'h8);
    chk(last0, 32'h4);
    chk(dma_seen, 32'h0);
    chk(last1, 32'h2B4);
    cfg(32'h9, 32'h1, 32'h64, 32'h0);
    fire(0);
    l0 = lat;
    wait_idle();
    cfg(32'h49, 32'h1, 32'h64, 32'h0);
    fire(0);
    chk((lat - l0) inside {[99:101]}, 32'h1);
    wait_idle();
    cfg(32'hC9, 32'h1, 32'h2, 32'h0);
    fire(0);
    chk((lat - l0) inside {[78:82]}, 32'h1);
    wait_idle();
    for (int g = 0; g < 3; g++) begin
      cfg(gc[g], 32'h2, 32'h0, gd[g]);
      fire(0);
      wait_cnt(4);
      fire(3);
      if (g == 0) l0 = lat;
      chk((lat - l0 - ge[g]) inside {[-2:2]}, 32'h1);
      wait_idle();
    end
    for (int m = 0; m < 3; m++) begin
      cfg(32'h409 | (m << 11), 32'h3, 32'h0, 32'h0);
      fire(0);
      wait_cnt(6);
      wr(ADDR_CMD, 32'h2);
      wait_idle();
      chk((cnt0 - base) inside {[lo[m]:lo[m] + (m == 0)]}, 32'h1);
    end
    wr(ADDR_RETRIG, 32'h1);
    cfg(32'h209, 32'h1, 32'h0, 32'h0);
    fire(0);
    wait_cnt(4);
    repeat (5) @(posedge pclk);
    fire(0);
    wait_cnt(8);
    repeat (5) @(posedge pclk);
    fire(0);
    chk(cnt0 - base, 32'h8);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL1, k ? 32'h6 : 32'h9);
      wr(ADDR_CTRL0, 32'h9);
      wr(ADDR_CMD, 32'h4);
      if (k == 0) begin
        wr(ADDR_UPDATES, 32'h800);
        chk(dma_req, 32'h1);
      end
      repeat (1030) wr(ADDR_FIFO, 32'h0);
      chk(dma_req, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rdat[13:3], k ? FIFO_ONE_CH : FIFO_TWO_CH);
    end
    wrap_up();
  end
endmodule
